// file: inc/spu_pkg.sv
// Contract
// - Pointer is 16 bits, upper byte fixed.
// - Reset or reinit loads 0x01ff.
// - Push writes first, then decrements.
// - Pop increments first, then reads.
// - Decrement below bottom wraps to top silently.
// - Increment above top wraps to bottom silently.
// - Low byte directly readable and writable.
// - Interrupt saves PC low first, then rest.
// - Call uses two bytes, interrupt five.
// - Interrupt return restores context in reverse.
// - Call saves return address; push/pop supported.
package spu_pkg;
    localparam logic [7:0]  SPU_PAGE       = 8'h01;
    localparam logic [7:0]  SPU_LOW_RESET  = 8'hff;
    localparam logic [15:0] SPU_RESET      = 16'h01ff;
    localparam logic [2:0]  SPU_CALL_BYTES = 3'h2;
    localparam logic [2:0]  SPU_INT_BYTES  = 3'h5;

    // Operation codes from the instruction sequencer.
    typedef enum logic [2:0] {
        SPU_OP_NONE  = 3'h0,
        SPU_OP_PUSH  = 3'h1,
        SPU_OP_POP   = 3'h2,
        SPU_OP_CALL  = 3'h3,
        SPU_OP_RET   = 3'h4,
        SPU_OP_INT   = 3'h5,
        SPU_OP_IRET  = 3'h6,
        SPU_OP_REINIT = 3'h7
    } spu_op_t;

    // Sequencer states, Gray coded along save/restore bursts.
    typedef enum logic [1:0] {
        SPU_IDLE = 2'b00,
        SPU_SAVE = 2'b01,
        SPU_LOAD = 2'b10
    } spu_state_t;

    // Memory access request toward the stack RAM.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } spu_mem_req_t;

    typedef struct packed {
        spu_state_t st;
        logic [7:0] low;
        logic [2:0] left;
        logic [7:0] pop_data;
        logic       pop_valid;
        logic       rd_pend;
    } spu_state_s_t;
endpackage

// file: design/spu_stack_ram.sv
// Stack page memory, 256 bytes, registered read data.
module spu_stack_ram
    import spu_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input  wire logic         clk_in,
    input  wire spu_mem_req_t req_in,
    output logic [7:0]        rdata_out
);
    logic [7:0] mem [DEPTH];

    // Write on request; read data always comes from a register.
    always_ff @(posedge clk_in) begin
        if (req_in.wr) begin
            mem[req_in.addr] <= req_in.data;
        end
        rdata_out <= mem[req_in.addr];
    end
endmodule

// file: design/spu_stack_pointer.sv
module spu_stack_pointer
    import spu_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Sequencer request; one byte per cycle during a save burst.
    input  wire spu_op_t     op_in,
    input  wire logic        op_valid_in,
    input  wire logic [7:0]  push_data_in,
    // Direct access to the pointer by the load instruction.
    input  wire logic        sp_wr_in,
    input  wire logic        sp_wr_hi_in,
    input  wire logic [7:0]  sp_wdata_in,
    output logic [15:0]      stack_pointer_out,
    // Results.
    output logic             busy_out,
    output logic             byte_req_out,
    output logic [7:0]       pop_data_out,
    output logic             pop_valid_out
);
    spu_state_s_t s_r;
    spu_state_s_t s_nxt;
    spu_mem_req_t req;
    logic [7:0]   rdata;

    ////////////////////////////////////////////////////////////////////////
    // Stack memory.
    spu_stack_ram #(
        .DEPTH (256)
    ) u_ram (
        .clk_in    (clk_in),
        .req_in    (req),
        .rdata_out (rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Upper byte is constant; only the low byte is state.
    assign stack_pointer_out = {SPU_PAGE, s_r.low};
    assign busy_out          = (s_r.st != SPU_IDLE);
    assign byte_req_out      = (s_r.st == SPU_SAVE);
    assign pop_data_out      = s_r.pop_data;
    assign pop_valid_out     = s_r.pop_valid;

    // Next state; calls and interrupts are multi-byte bursts where the
    // sequencer supplies one byte per cycle, PC low first.
    always_comb begin
        s_nxt           = s_r;
        s_nxt.pop_valid = 1'b0;
        s_nxt.rd_pend   = 1'b0;
        req             = '0;
        req.addr        = s_r.low;
        req.data        = push_data_in;
        if (s_r.rd_pend) begin
            s_nxt.pop_data  = rdata;
            s_nxt.pop_valid = 1'b1;
        end
        case (s_r.st)
            SPU_IDLE: begin
                if (op_valid_in) begin
                    case (op_in)
                        SPU_OP_PUSH: begin
                            req.wr    = 1'b1;
                            s_nxt.low = s_r.low - 8'h01;
                        end
                        SPU_OP_POP: begin
                            s_nxt.low     = s_r.low + 8'h01;
                            req.addr      = s_nxt.low;
                            req.rd        = 1'b1;
                            s_nxt.rd_pend = 1'b1;
                        end
                        SPU_OP_CALL: begin
                            s_nxt.st   = SPU_SAVE;
                            s_nxt.left = SPU_CALL_BYTES;
                        end
                        SPU_OP_INT: begin
                            s_nxt.st   = SPU_SAVE;
                            s_nxt.left = SPU_INT_BYTES;
                        end
                        SPU_OP_RET: begin
                            s_nxt.st   = SPU_LOAD;
                            s_nxt.left = SPU_CALL_BYTES;
                        end
                        SPU_OP_IRET: begin
                            s_nxt.st   = SPU_LOAD;
                            s_nxt.left = SPU_INT_BYTES;
                        end
                        SPU_OP_REINIT: s_nxt.low = SPU_LOW_RESET;
                        default: ;
                    endcase
                end else if (sp_wr_in && !sp_wr_hi_in) begin
                    s_nxt.low = sp_wdata_in;
                end
            end
            SPU_SAVE: begin
                // Write at the free slot, then step down.
                req.wr     = 1'b1;
                s_nxt.low  = s_r.low - 8'h01;
                s_nxt.left = s_r.left - 3'h1;
                if (s_r.left == 3'h1) begin
                    s_nxt.st = SPU_IDLE;
                end
            end
            SPU_LOAD: begin
                // Step up, then read: bytes return in reverse order.
                s_nxt.low     = s_r.low + 8'h01;
                req.addr      = s_nxt.low;
                req.rd        = 1'b1;
                s_nxt.rd_pend = 1'b1;
                s_nxt.left    = s_r.left - 3'h1;
                if (s_r.left == 3'h1) begin
                    s_nxt.st = SPU_IDLE;
                end
            end
            default: s_nxt.st = SPU_IDLE;
        endcase
    end

    // State register; reset selects the top of the stack.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_r     <= '0;
            s_r.low <= SPU_LOW_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence push_seq;
        op_valid_in && !busy_out && op_in == SPU_OP_PUSH;
    endsequence

    a_upper_fixed: assert property (@(posedge clk_in)
        stack_pointer_out[15:8] == SPU_PAGE)
        else $error("upper byte not fixed");
    a_reset_top: assert property (@(posedge clk_in)
        reset_in |=> stack_pointer_out == SPU_RESET)
        else $error("reset value wrong");
    a_push_dec: assert property (@(posedge clk_in) disable iff (reset_in)
        push_seq |=> s_r.low == $past(s_r.low) - 8'h01)
        else $error("push did not decrement");
    a_pop_data: assert property (@(posedge clk_in) disable iff (reset_in)
        (op_valid_in && !busy_out && op_in == SPU_OP_POP)
        |=> ##1 pop_valid_out)
        else $error("pop data missing");
    a_int_five: assert property (@(posedge clk_in) disable iff (reset_in)
        (op_valid_in && !busy_out && op_in == SPU_OP_INT)
        |=> byte_req_out [*5] ##1 !busy_out)
        else $error("interrupt save not five bytes");
    a_call_two: assert property (@(posedge clk_in) disable iff (reset_in)
        (op_valid_in && !busy_out && op_in == SPU_OP_CALL)
        |=> byte_req_out [*2] ##1 !busy_out)
        else $error("call save not two bytes");
    a_wrap_down: assert property (@(posedge clk_in) disable iff (reset_in)
        (push_seq and s_r.low == 8'h00) |=> s_r.low == 8'hff)
        else $error("no wrap at bottom");
    a_hi_ignore: assert property (@(posedge clk_in) disable iff (reset_in)
        (sp_wr_in && sp_wr_hi_in && !op_valid_in && !busy_out)
        |=> $stable(s_r.low))
        else $error("upper write changed pointer");

    ////////////////////////////////////////////////////////////////////////
    // Requests are only taken while idle; each taken kind except call and interrupt gets a name.
    sequence pop_seq;
        op_valid_in && !busy_out && op_in == SPU_OP_POP;
    endsequence
    sequence reinit_seq;
        op_valid_in && !busy_out && op_in == SPU_OP_REINIT;
    endsequence
    sequence ret_seq;
        op_valid_in && !busy_out && op_in == SPU_OP_RET;
    endsequence
    sequence iret_seq;
        op_valid_in && !busy_out && op_in == SPU_OP_IRET;
    endsequence
    sequence low_wr_seq;
        sp_wr_in && !sp_wr_hi_in && !op_valid_in && !busy_out;
    endsequence

    // A read is two steps: the RAM access, then the registered byte.
    sequence read_back_seq;
        s_r.rd_pend ##1 pop_valid_out;
    endsequence

    // Pop side: increment before the read, wrap silently at the top.
    a_pop_inc: assert property (
        @(posedge clk_in) disable iff (reset_in)
        pop_seq |=> s_r.low == $past(s_r.low) + 8'h01)
        else $error("pop did not increment");
    a_wrap_up: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (pop_seq and s_r.low == 8'hff) |=> s_r.low == 8'h00)
        else $error("no wrap at top");

    // Reinit and reset both land on the top of the stack, idle.
    a_reinit_top: assert property (
        @(posedge clk_in) disable iff (reset_in)
        reinit_seq |=> stack_pointer_out == SPU_RESET)
        else $error("reinit value wrong");
    a_reset_idle: assert property (
        @(posedge clk_in)
        reset_in |=> !busy_out && !pop_valid_out)
        else $error("not idle after reset");

    // Direct load of the low byte takes effect on the next cycle.
    a_low_write: assert property (
        @(posedge clk_in) disable iff (reset_in)
        low_wr_seq |=> s_r.low == $past(sp_wdata_in))
        else $error("low byte write lost");

    // Restore bursts read only; they never ask for save bytes.
    a_ret_two: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ret_seq |=> (busy_out && !byte_req_out) [*2] ##1 !busy_out)
        else $error("return restore not two bytes");
    a_iret_five: assert property (
        @(posedge clk_in) disable iff (reset_in)
        iret_seq |=> (busy_out && !byte_req_out) [*5] ##1 !busy_out)
        else $error("interrupt restore not five bytes");
    a_ret_data: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ret_seq |=> ##1 read_back_seq)
        else $error("restore byte missing");

    // Every save byte lands at the free slot before the step down.
    a_save_addr: assert property (
        @(posedge clk_in) disable iff (reset_in)
        byte_req_out |-> req.wr && req.addr == s_r.low)
        else $error("save byte misplaced");
endmodule

// file: bench/spu_seq_model.sv
// Sequencer side of a save burst: hands one context byte per request.
module spu_seq_model (
    // Clock and reset.
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // Byte handshake.
    input  wire logic       byte_req_in,
    output logic [7:0]      data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    // Bytes count up so each saved byte is distinct and traceable.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_r <= 8'h00;
        end else if (byte_req_in) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    assign data_out = 8'h50 + cnt_r;
endmodule

// file: bench/spu_stack_pointer_tb.sv
module spu_stack_pointer_tb import spu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, op_v, wr, wr_hi, busy, breq, pv;
    spu_op_t op;
    logic [7:0] bdata, wdata, pdata, mdata;
    logic [15:0] sp;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int pv_count = 0;
    int breq_count = 0;
    int busy_count = 0;
////////////////////////////////////////////////////////////////////////////
    spu_stack_pointer dut (.clk_in(clk), .reset_in(rst), .op_in(op),
        .op_valid_in(op_v), .push_data_in(busy ? mdata : bdata),
        .sp_wr_in(wr), .sp_wr_hi_in(wr_hi), .sp_wdata_in(wdata),
        .stack_pointer_out(sp), .busy_out(busy), .byte_req_out(breq),
        .pop_data_out(pdata), .pop_valid_out(pv));
    spu_seq_model seq (.clk_in(clk), .reset_in(rst), .byte_req_in(breq),
        .data_out(mdata));
////////////////////////////////////////////////////////////////////////////
    // Free-running clock; a hang is cut short by the cycle ceiling.
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_of_test();
        end
    end
    // Pulse counters, so one-cycle outputs are seen while they stand.
    always @(posedge clk) begin
        if (pv === 1'b1) begin
            pv_count++;
        end
        if (breq === 1'b1) begin
            breq_count++;
        end
        if (busy === 1'b1) begin
            busy_count++;
        end
    end
    task automatic chk_n(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_sp(input logic [15:0] exp);
        n_checks++;
        if (sp !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, sp, exp);
        end
    endtask
    task automatic chk_b(input logic [7:0] exp);
        n_checks++;
        if (pdata !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, pdata, exp);
        end
    endtask
    // Pulses one request, then waits out the burst and the pop latency.
    task automatic do_op(input spu_op_t o, input logic [7:0] d);
        int i;
        i = 0;
        op = o;
        op_v = 1'b1;
        bdata = d;
        @(negedge clk);
        op_v = 1'b0;
        op = SPU_OP_NONE;
        while (busy !== 1'b0 && i < 20) begin
            @(negedge clk);
            i++;
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic wr_sp(input logic hi, input logic [7:0] d);
        wr = 1'b1;
        wr_hi = hi;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        wr_hi = 1'b0;
        @(negedge clk);
    endtask
////////////////////////////////////////////////////////////////////////////
    // Save bursts first, so the model's byte numbering starts at 0x50.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        op = SPU_OP_NONE;
        op_v = 1'b0;
        bdata = 8'h00;
        wr = 1'b0;
        wr_hi = 1'b0;
        wdata = 8'h00;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk_sp(16'h01ff);
        do_op(SPU_OP_INT, 8'h00);
        chk_sp(16'h01fa);
        do_op(SPU_OP_IRET, 8'h00);
        chk_sp(16'h01ff);
        chk_b(8'h50);
        do_op(SPU_OP_CALL, 8'h00);
        chk_sp(16'h01fd);
        do_op(SPU_OP_RET, 8'h00);
        chk_b(8'h55);
        do_op(SPU_OP_PUSH, 8'ha5);
        chk_sp(16'h01fe);
        do_op(SPU_OP_PUSH, 8'h3c);
        do_op(SPU_OP_POP, 8'h00);
        chk_b(8'h3c);
        do_op(SPU_OP_POP, 8'h00);
        chk_b(8'ha5);
        chk_sp(16'h01ff);
        do_op(SPU_OP_POP, 8'h00);
        chk_sp(16'h0100);
        do_op(SPU_OP_PUSH, 8'h77);
        chk_sp(16'h01ff);
        do_op(SPU_OP_POP, 8'h00);
        chk_b(8'h77);
        do_op(SPU_OP_REINIT, 8'h00);
        chk_sp(16'h01ff);
        wr_sp(1'b0, 8'h42);
        chk_sp(16'h0142);
        wr_sp(1'b1, 8'h99);
        chk_sp(16'h0142);
        chk_n(pv_count, 11);
        chk_n(breq_count, 7);
        chk_n(busy_count, 14);
        end_of_test();
    end
endmodule
